// >>> src/pbs_dev.sv
// Memory end: burst sequencing, wait generation and async access
`timescale 1ns/10ps
module pbs_dev (
	input wire logic CORE_CLK, // Core clock
	input wire logic RST, // Synchronous reset, active high
	output logic REFRESH_MISSED, // Select held low too long, sticky
	pbs_if.dev BUS // Memory bus
);
	localparam int NW = 1 << pbs_pkg::AW;

	// Word at the current and at the next address, each built from both byte lanes
	wire [pbs_pkg::DW-1:0] rd_cur, rd_inc;
	pbs_pkg::pbs_dstate_type state_r, state_nxt;
	logic clk_prev_r, adv_prev_r;
	logic [2:0] cnt_r, cnt_nxt;
	logic [pbs_pkg::AW-1:0] addr_r, addr_nxt;
	logic wr_r, wr_nxt, fixed_r, fixed_nxt, first_r, first_nxt;
	logic wait_r, wait_nxt, rowend_r, rowend_nxt;
	logic [pbs_pkg::DW-1:0] dq_r, dq_nxt;
	logic [9:0] low_cnt_r;
	logic missed_r;

	////////////////////////////////////////////////////////////////////
	wire rise = BUS.bus_clk & ~clk_prev_r;
	wire adv = ~BUS.address_valid_n;
	wire adv_fall = adv & adv_prev_r;
	wire sel = ~BUS.select_n;
	wire in_idle = (state_r == pbs_pkg::D_IDLE);
	wire in_data = (state_r == pbs_pkg::D_DATA);
	wire in_async = (state_r == pbs_pkg::D_ASYNC);
	wire burst_start = sel & rise & adv & BUS.cfg_sync &
		(in_idle | in_async | (in_data & first_r));
	wire fixed_read = in_data & fixed_r & ~wr_r;
	wire async_start = sel & adv_fall & ~rise &
		(~BUS.cfg_sync | fixed_read);
	wire row_last = &addr_r[pbs_pkg::ROW_W-1:0];
	wire [pbs_pkg::ROW_W-1:0] col_inc = addr_r[pbs_pkg::ROW_W-1:0] + 4'h1;
	wire [pbs_pkg::AW-1:0] addr_inc = BUS.cfg_wrap ?
		{addr_r[pbs_pkg::AW-1:pbs_pkg::ROW_W], col_inc} : addr_r + 8'h01;
	// Early wait flags the last word of a row one clock ahead
	wire row_wait = ~BUS.cfg_wrap &
		(BUS.cfg_wait_early ? &col_inc : row_last);
	wire xfer = in_data & rise & ~rowend_r & ~burst_start;
	wire mem_we = sel & ~async_start & ((xfer & wr_r) |
		(in_async & ~BUS.we_n));

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		addr_nxt = addr_r;
		wr_nxt = wr_r;
		fixed_nxt = fixed_r;
		first_nxt = first_r;
		wait_nxt = wait_r;
		rowend_nxt = rowend_r;
		dq_nxt = dq_r;
		if (!sel)
		begin
			state_nxt = pbs_pkg::D_IDLE;
			wait_nxt = 1'b0;
			rowend_nxt = 1'b0;
		end
		else if (burst_start)
		begin
			// Wait stands from the address clock for LC clocks
			state_nxt = pbs_pkg::D_LAT;
			addr_nxt = BUS.addr;
			wr_nxt = ~BUS.we_n;
			fixed_nxt = BUS.cfg_fixed;
			first_nxt = 1'b0;
			rowend_nxt = 1'b0;
			cnt_nxt = BUS.latency_code;
			wait_nxt = 1'b1;
		end
		else if (async_start)
		begin
			state_nxt = pbs_pkg::D_ASYNC;
			addr_nxt = BUS.addr;
			wait_nxt = 1'b0;
		end
		else
		begin
			case (state_r)
				pbs_pkg::D_LAT:
				begin
					if (rise)
					begin
						cnt_nxt = cnt_r - 3'h1;
						// First word lands LC+1 clocks after the address
						if (cnt_r <= 3'h1)
						begin
							state_nxt = pbs_pkg::D_DATA;
							wait_nxt = 1'b0;
							dq_nxt = rd_cur;
						end
					end
				end
				pbs_pkg::D_DATA:
				begin
					// dq only moves on a rise, so a stopped clock holds it
					if (xfer)
					begin
						first_nxt = 1'b1;
						addr_nxt = addr_inc;
						dq_nxt = rd_inc;
						wait_nxt = row_wait;
						rowend_nxt = ~BUS.cfg_wrap & row_last;
					end
				end
				pbs_pkg::D_ASYNC:
				begin
					dq_nxt = rd_cur;
				end
				default:
				begin
					state_nxt = pbs_pkg::D_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	genvar b;
	generate
		for (b = 0; b < 2; b++)
		begin : g_lane
			// One array per lane, so each has a single writing process
			logic [7:0] lane_mem [0:NW-1];
			wire lane_n = (b == 0) ? BUS.lower_byte_select_n :
				BUS.upper_byte_select_n;
			assign rd_cur[b*8 +: 8] = lane_mem[addr_r];
			assign rd_inc[b*8 +: 8] = lane_mem[addr_inc];
			always_ff @(posedge CORE_CLK)
			begin
				if (mem_we & ~lane_n)
					lane_mem[addr_r] <= BUS.dq[b*8 +: 8];
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			state_r <= pbs_pkg::D_IDLE;
			clk_prev_r <= 1'b0;
			adv_prev_r <= 1'b0;
			cnt_r <= 3'h0;
			addr_r <= '0;
			wr_r <= 1'b0;
			fixed_r <= 1'b0;
			first_r <= 1'b0;
			wait_r <= 1'b0;
			rowend_r <= 1'b0;
			dq_r <= '0;
			low_cnt_r <= 10'h000;
			missed_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			clk_prev_r <= BUS.bus_clk;
			adv_prev_r <= BUS.address_valid_n;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			wr_r <= wr_nxt;
			fixed_r <= fixed_nxt;
			first_r <= first_nxt;
			wait_r <= wait_nxt;
			rowend_r <= rowend_nxt;
			dq_r <= dq_nxt;
			// Any clocked select-high cycle counts as a refresh slot
			low_cnt_r <= sel ? low_cnt_r + (missed_r ? 10'h000 : 10'h001)
				: 10'h000;
			if (sel && low_cnt_r >= 10'(pbs_pkg::CEM_CYC))
				missed_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	assign BUS.dq_d_o = dq_r;
	assign BUS.dq_d_oe = sel & ~BUS.oe_n &
		((in_data & ~wr_r) | (in_async & BUS.we_n));
	assign BUS.wait_o = BUS.cfg_wait_high ? wait_r : ~wait_r;
	assign BUS.wait_oe = sel;
	assign REFRESH_MISSED = missed_r;
endmodule

// >>> src/pbs_host.sv
// Controller end: register port and burst bus sequencing
//
// Summary of operation
// - Clock static while a read burst is suspended
// - Suspended read keeps valid data with output on
// - Row end: drop select within wait deadline
// - Wait asserted for latency code clocks
// - Code 2 gives 3 clocks, 4 gives 5
// - Wait polarity selectable, active low supported
// - Refresh slot: clocked or 15 ns select high
// - Select may stay low across bursts, bounded
// - Select high between async and variable bursts; chaining does not check the mode and can keep select low across the switch
// - After fixed read, async starts at valid fall
// - Select high 5 ns between async operations; chaining does not test async mode and keeps select low into the next one
// - Interrupt only after first word transferred
// - Select never low beyond 4 microseconds
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module pbs_host (
	input wire logic CORE_CLK, // Core clock
	input wire logic RST, // Synchronous reset, active high
	input wire logic [7:0] ADDR, // Register byte address
	input wire logic [31:0] WDATA, // Register write data
	input wire logic WR, // Write strobe
	input wire logic RD, // Read strobe
	output logic [31:0] RDATA, // Read data, cycle after RD
	pbs_if.host BUS // Memory bus
);
	pbs_pkg::pbs_hstate_type st_r;
	logic [7:0] cfg_r;
	logic [pbs_pkg::AW-1:0] start_r;
	logic [pbs_pkg::DW-1:0] wdata_r, rdata_r;
	logic [3:0] len_r, wcnt_r;
	logic wrcmd_r, pend_r, row_abort_r, cem_abort_r;
	logic clk_r, sel_n_r, adv_n_r, we_n_r, dq_oe_r;
	logic [pbs_pkg::AW-1:0] baddr_r;
	logic [pbs_pkg::DW-1:0] dq_o_r;
	logic addr_done_r, got_first_r, end_r;
	logic [9:0] low_cnt_r;
	logic [2:0] gap_r;
	logic [31:0] rd_r;

	////////////////////////////////////////////////////////////////////
	wire wr_ctrl = WR & (ADDR == pbs_pkg::REG_CTRL) &
		WDATA[pbs_pkg::CTRL_START];
	wire wr_stat = WR & (ADDR == pbs_pkg::REG_STATUS);
	wire run = (st_r == pbs_pkg::H_RUN);
	wire rise_now = run & ~clk_r;
	wire fall_now = run & clk_r;
	wire wait_act = cfg_r[pbs_pkg::CFG_WAIT_HIGH] ? BUS.wait_o :
		~BUS.wait_o;
	wire data_rise = rise_now & addr_done_r & ~end_r;
	wire word_ok = data_rise & ~wait_act;
	wire last_word = word_ok & (wcnt_r == len_r);
	wire row_hit = data_rise & wait_act & got_first_r;
	wire cem_hit = low_cnt_r >= 10'(pbs_pkg::CEM_CYC - pbs_pkg::CEM_MARGIN);
	// Chaining keeps select low; the low-time guard still bounds it
	wire chain = fall_now & pend_r & got_first_r & ~end_r &
		~cem_hit;
	wire launch = (st_r == pbs_pkg::H_IDLE) & pend_r;
	wire [31:0] status = {24'h0, wcnt_r, 1'b0, cem_abort_r, row_abort_r,
		(st_r != pbs_pkg::H_IDLE) | pend_r};
	wire [31:0] rd_mux =
		(ADDR == pbs_pkg::REG_ADDR) ? {24'h0, start_r} :
		(ADDR == pbs_pkg::REG_WDATA) ? {16'h0, wdata_r} :
		(ADDR == pbs_pkg::REG_CFG) ? {24'h0, cfg_r} :
		(ADDR == pbs_pkg::REG_STATUS) ? status :
		(ADDR == pbs_pkg::REG_RDATA) ? {16'h0, rdata_r} : 32'h0;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			cfg_r <= pbs_pkg::CFG_RST;
			start_r <= '0;
			wdata_r <= '0;
			len_r <= 4'h0;
			wrcmd_r <= 1'b0;
			pend_r <= 1'b0;
			row_abort_r <= 1'b0;
			cem_abort_r <= 1'b0;
			rd_r <= 32'h0;
		end
		else
		begin
			rd_r <= RD ? rd_mux : 32'h0;
			if (WR && ADDR == pbs_pkg::REG_ADDR)
				start_r <= WDATA[pbs_pkg::AW-1:0];
			if (WR && ADDR == pbs_pkg::REG_WDATA)
				wdata_r <= WDATA[pbs_pkg::DW-1:0];
			if (WR && ADDR == pbs_pkg::REG_CFG)
				cfg_r <= WDATA[7:0];
			if (wr_ctrl)
			begin
				wrcmd_r <= WDATA[pbs_pkg::CTRL_WRITE];
				len_r <= WDATA[pbs_pkg::CTRL_LEN_LSB +: 4];
			end
			pend_r <= wr_ctrl | (pend_r & ~launch & ~chain);
			// A new event beats a clear in the same cycle
			row_abort_r <= row_hit | (row_abort_r &
				~(wr_stat & WDATA[pbs_pkg::ST_ROW_ABORT]));
			cem_abort_r <= (fall_now & cem_hit & ~end_r) | (cem_abort_r &
				~(wr_stat & WDATA[pbs_pkg::ST_CEM_ABORT]));
		end
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			st_r <= pbs_pkg::H_IDLE;
			clk_r <= 1'b0;
			sel_n_r <= 1'b1;
			adv_n_r <= 1'b1;
			we_n_r <= 1'b1;
			dq_oe_r <= 1'b0;
			baddr_r <= '0;
			dq_o_r <= '0;
			rdata_r <= '0;
			wcnt_r <= 4'h0;
			addr_done_r <= 1'b0;
			got_first_r <= 1'b0;
			end_r <= 1'b0;
			low_cnt_r <= 10'h000;
			gap_r <= 3'h0;
		end
		else
		begin
			// The bus clock only toggles while a burst runs
			clk_r <= run ? ~clk_r : 1'b0;
			low_cnt_r <= sel_n_r ? 10'h000 : low_cnt_r + 10'h001;
			if (launch || chain)
			begin
				st_r <= pbs_pkg::H_RUN;
				sel_n_r <= 1'b0;
				adv_n_r <= 1'b0;
				we_n_r <= ~wrcmd_r;
				dq_oe_r <= wrcmd_r;
				baddr_r <= start_r;
				dq_o_r <= wdata_r;
				wcnt_r <= 4'h0;
				addr_done_r <= 1'b0;
				got_first_r <= 1'b0;
				end_r <= 1'b0;
			end
			else if (rise_now)
			begin
				addr_done_r <= 1'b1;
				if (word_ok)
				begin
					got_first_r <= 1'b1;
					if (we_n_r)
						rdata_r <= BUS.dq;
					wcnt_r <= wcnt_r + 4'h1;
				end
				end_r <= end_r | last_word | row_hit;
			end
			else if (fall_now)
			begin
				adv_n_r <= 1'b1;
				if (got_first_r)
					dq_o_r <= wdata_r + {12'h000, wcnt_r};
				// Select rises on the next fall, inside the row deadline
				if (end_r || cem_hit)
				begin
					st_r <= pbs_pkg::H_GAP;
					sel_n_r <= 1'b1;
					we_n_r <= 1'b1;
					dq_oe_r <= 1'b0;
					gap_r <= 3'(pbs_pkg::HIGH_CYC);
				end
			end
			else if (st_r == pbs_pkg::H_GAP)
			begin
				// Long enough for both the refresh slot and the 5 ns gap
				gap_r <= gap_r - 3'h1;
				if (gap_r <= 3'h1)
					st_r <= pbs_pkg::H_IDLE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	assign BUS.bus_clk = clk_r;
	assign BUS.select_n = sel_n_r;
	assign BUS.address_valid_n = adv_n_r;
	assign BUS.we_n = we_n_r;
	assign BUS.oe_n = ~(run & we_n_r & addr_done_r);
	assign BUS.lower_byte_select_n = sel_n_r;
	assign BUS.upper_byte_select_n = sel_n_r;
	assign BUS.addr = baddr_r;
	assign BUS.dq_h_o = dq_o_r;
	assign BUS.dq_h_oe = dq_oe_r;
	assign BUS.latency_code = cfg_r[2:0];
	assign BUS.cfg_fixed = cfg_r[pbs_pkg::CFG_FIXED];
	assign BUS.cfg_wait_high = cfg_r[pbs_pkg::CFG_WAIT_HIGH];
	assign BUS.cfg_wait_early = cfg_r[pbs_pkg::CFG_WAIT_EARLY];
	assign BUS.cfg_wrap = cfg_r[pbs_pkg::CFG_WRAP];
	assign BUS.cfg_sync = cfg_r[pbs_pkg::CFG_SYNC];
	assign RDATA = rd_r;
endmodule

// >>> src/pbs_if.sv
// Bus pins and configuration sideband between controller and memory
`timescale 1ns/10ps
interface pbs_if;
	logic bus_clk;
	logic select_n;
	logic address_valid_n;
	logic oe_n;
	logic we_n;
	logic lower_byte_select_n;
	logic upper_byte_select_n;
	logic [pbs_pkg::AW-1:0] addr;
	logic [pbs_pkg::DW-1:0] dq_h_o;
	logic dq_h_oe;
	logic [pbs_pkg::DW-1:0] dq_d_o;
	logic dq_d_oe;
	logic [pbs_pkg::DW-1:0] dq;
	logic wait_o;
	logic wait_oe;
	logic [2:0] latency_code;
	logic cfg_fixed;
	logic cfg_wait_high;
	logic cfg_wait_early;
	logic cfg_wrap;
	logic cfg_sync;

	// Shared data wire level; undriven reads as zero
	assign dq = dq_h_oe ? dq_h_o : (dq_d_oe ? dq_d_o : '0);

	modport host (output bus_clk, select_n, address_valid_n, oe_n, we_n,
		lower_byte_select_n, upper_byte_select_n, addr, dq_h_o, dq_h_oe,
		latency_code, cfg_fixed, cfg_wait_high, cfg_wait_early, cfg_wrap,
		cfg_sync, input dq, wait_o, wait_oe);
	modport dev (input bus_clk, select_n, address_valid_n, oe_n, we_n,
		lower_byte_select_n, upper_byte_select_n, addr, dq,
		latency_code, cfg_fixed, cfg_wait_high, cfg_wait_early, cfg_wrap,
		cfg_sync, output dq_d_o, dq_d_oe, wait_o, wait_oe);
endinterface

// >>> src/pbs_pkg.sv
// Shared constants for the burst pseudo-static RAM bus pair
package pbs_pkg;
	localparam int AW = 8;
	localparam int DW = 16;
	localparam int ROW_W = 4;
	localparam int CLK_NS = 4;
	localparam int T_CEM_NS = 4000;
	localparam int CEM_CYC = T_CEM_NS / CLK_NS;
	localparam int CEM_MARGIN = 4;
	localparam int T_REF_NS = 15;
	localparam int REF_CYC = T_REF_NS / CLK_NS + 1;
	localparam int T_GAP_NS = 5;
	localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int HIGH_CYC = (REF_CYC > GAP_CYC) ? REF_CYC : GAP_CYC;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_CFG = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_RDATA = 8'h14;
	localparam int CTRL_START = 0;
	localparam int CTRL_WRITE = 1;
	localparam int CTRL_LEN_LSB = 4;
	localparam int CFG_FIXED = 3;
	localparam int CFG_WAIT_HIGH = 4;
	localparam int CFG_WAIT_EARLY = 5;
	localparam int CFG_WRAP = 6;
	localparam int CFG_SYNC = 7;
	localparam logic [7:0] CFG_RST = 8'hD3;
	localparam int ST_BUSY = 0;
	localparam int ST_ROW_ABORT = 1;
	localparam int ST_CEM_ABORT = 2;
	localparam int ST_CNT_LSB = 4;
	typedef enum {D_IDLE, D_LAT, D_DATA, D_ASYNC} pbs_dstate_type;
	typedef enum {H_IDLE, H_RUN, H_GAP} pbs_hstate_type;
endpackage

// >>> test/pbs_bus_checker.sv
// Concurrent checks on the burst bus between controller and memory
`timescale 1ns/10ps
module pbs_bus_checker (
	input wire logic CORE_CLK, // Core clock
	input wire logic RST, // Synchronous reset
	input wire logic bus_clk, // Burst clock
	input wire logic select_n, // Chip select
	input wire logic address_valid_n, // Address strobe
	input wire logic [pbs_pkg::DW-1:0] dq_d_o, // Memory data out
	input wire logic wait_o, // Wait pin
	input wire logic [2:0] latency_code, // Latency code
	input wire logic cfg_wait_high // Wait active high
);
	localparam int LOW_MAX = 1000;
	logic wact;
	logic [3:0] lat2;
	logic [4:0] wcnt_r;
	logic [10:0] low_r;

	////////////////////////////////////////
	assign wact = (wait_o == cfg_wait_high);
	// Code 0 behaves as 1; one bus clock is two core cycles
	assign lat2 = (latency_code == 3'h0) ? 4'h2 : {latency_code, 1'b0};

	always_ff @(posedge CORE_CLK)
	begin
		wcnt_r <= (RST || !wact || select_n) ? 5'h00 : wcnt_r + 5'h01;
		low_r <= (RST || select_n) ? 11'h000 : low_r + 11'h001;
	end

	////////////////////////////////////////
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	chk_wait_len: assert property ((!wact && $past(wact) && !select_n
		&& !$past(select_n)) |-> wcnt_r == {1'b0, lat2})
		else $error("wait length differs from latency code");
	chk_wait_bound: assert property (wcnt_r <= 5'h10)
		else $error("wait held too long without select release");
	chk_wait_pol: assert property ($fell(select_n) |-> !wact)
		else $error("wait active at select fall");
	chk_clk_runs: assert property ((!select_n && !$past(select_n))
		|-> bus_clk != $past(bus_clk))
		else $error("bus clock stalled while selected");
	chk_data_hold: assert property ($changed(dq_d_o)
		|-> $past(bus_clk) && !$past(bus_clk, 2))
		else $error("memory data changed without clock rise");
	chk_gap_high: assert property ($rose(select_n) |-> select_n[*4])
		else $error("select high gap too short");
	chk_low_limit: assert property (low_r < LOW_MAX)
		else $error("select low too long");
	chk_irq_after_word: assert property (($fell(address_valid_n)
		&& !$past(select_n)) |-> !wact)
		else $error("burst interrupted before first word");
endmodule

// >>> test/psram_burst_bus_sequencing_tb.sv
// Self-checking bench for the burst bus controller and memory pair
`timescale 1ns/10ps
module psram_burst_bus_sequencing_tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic miss;
	logic [31:0] v;
	logic [31:0] wd;
	logic [7:0] a;
	int error_cnt = 0;
	int check_count = 0;

	pbs_if bus ();
	pbs_host pbs_host_i (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BUS(bus));
	pbs_dev pbs_dev_i (.CORE_CLK(core_clk), .RST(rst),
		.REFRESH_MISSED(miss), .BUS(bus));
	pbs_bus_checker pbs_bus_checker_i (.CORE_CLK(core_clk), .RST(rst),
		.bus_clk(bus.bus_clk), .select_n(bus.select_n),
		.address_valid_n(bus.address_valid_n), .dq_d_o(bus.dq_d_o),
		.wait_o(bus.wait_o), .latency_code(bus.latency_code),
		.cfg_wait_high(bus.cfg_wait_high));

	always #2 core_clk = ~core_clk;

	////////////////////////////////////////
	task automatic reg_wr(input logic [7:0] ra, input logic [31:0] d);
		@(posedge core_clk);
		addr <= ra;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] ra);
		@(posedge core_clk);
		addr <= ra;
		rd <= 1'b1;
		@(posedge core_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		v = 32'h00000001;
		while (v[0] !== 1'b0 && n < 2000)
		begin
			reg_rd(pbs_pkg::REG_STATUS);
			n++;
		end
		if (n >= 2000)
			error_cnt++;
	endtask

	// Length field holds words minus one
	task automatic burst(input logic wrt, input logic [7:0] ba,
		input logic [3:0] lm1);
		reg_wr(pbs_pkg::REG_ADDR, {24'h000000, ba});
		reg_wr(pbs_pkg::REG_CTRL, {24'h000000, lm1, 2'b00, wrt, 1'b1});
		wait_idle();
	endtask

	task automatic complete_run();
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		reg_rd(pbs_pkg::REG_CFG);
		check("cfg", {24'h000000, pbs_pkg::CFG_RST}, v);
		reg_wr(8'h18, 32'hFFFFFFFF);
		reg_rd(8'h18);
		check("unmapped", 32'h00000000, v);
		// Every latency code, both latency modes, both wait polarities
		for (int i = 0; i < 16; i++)
		begin
			reg_wr(pbs_pkg::REG_CFG,
				{24'h000000, 2'b11, 1'b0, i[0] ^ i[3], i[3], i[2:0]});
			wd = {16'h0000, 8'h5A, i[3:0], 4'h0};
			a = {i[3:0], 4'h4};
			reg_wr(pbs_pkg::REG_WDATA, wd);
			burst(1'b1, a, 4'h3);
			burst(1'b0, a, 4'h3);
			reg_rd(pbs_pkg::REG_RDATA);
			check("last word", wd + 32'h00000003, v);
			reg_rd(pbs_pkg::REG_STATUS);
			check("status", 32'h00000040, v);
			burst(1'b0, a + 8'h02, 4'h0);
			reg_rd(pbs_pkg::REG_RDATA);
			check("single word", wd + 32'h00000002, v);
		end
		// Clockless mode: the memory answers from the address strobe alone
		reg_wr(pbs_pkg::REG_CFG, 32'h00000053);
		burst(1'b0, 8'hF6, 4'h0);
		reg_rd(pbs_pkg::REG_RDATA);
		check("async word", 32'h00005AF2, v);
		// Wrap off across a row end, with and without early wait
		for (int j = 0; j < 2; j++)
		begin
			reg_wr(pbs_pkg::REG_CFG, {24'h000000, 2'b10, j[0], 5'h13});
			burst(1'b0, 8'h0E, 4'h3);
			reg_rd(pbs_pkg::REG_STATUS);
			check("row abort", 32'h00000002, v & 32'h00000007);
			reg_wr(pbs_pkg::REG_STATUS, 32'h00000002);
			reg_rd(pbs_pkg::REG_STATUS);
			check("row clear", 32'h00000000, v & 32'h00000007);
		end
		// Back-to-back starts chain interrupts until the low limit hits
		reg_wr(pbs_pkg::REG_CFG, {24'h000000, pbs_pkg::CFG_RST});
		repeat (200)
		begin
			reg_wr(pbs_pkg::REG_CTRL, 32'h000000F1);
			repeat (4) @(posedge core_clk);
		end
		wait_idle();
		reg_rd(pbs_pkg::REG_STATUS);
		check("low abort", 32'h00000004, v & 32'h00000004);
		check("refresh", 32'h00000000, {31'h00000000, miss});
		complete_run();
	end

	// Whole run needs a few thousand cycles
	initial
	begin
		#200000;
		error_cnt++;
		complete_run();
	end
endmodule
